//--- core/aoc_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * converter output and mode control block.
 * Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
 */
`ifndef AOC_REGS_SVH
`define AOC_REGS_SVH

// register byte offsets
`define AOC_CTRL_OFS      12'h000
`define AOC_STATUS_OFS    12'h004
`define AOC_SAMPLE_OFS    12'h008
`define AOC_COUNT_OFS     12'h00c

// control register fields
`define AOC_CTRL_SERIAL   0
`define AOC_CTRL_FMT_LO   1
`define AOC_CTRL_FMT_HI   2
`define AOC_CTRL_DCS      3
`define AOC_CTRL_STANDBY  4
`define AOC_CTRL_CLKINV   5
`define AOC_CTRL_RESET    32'h0000_0008

// status register fields
`define AOC_STAT_PDOWN    0
`define AOC_STAT_STANDBY  1
`define AOC_STAT_DCS      2
`define AOC_STAT_FMT_LO   3
`define AOC_STAT_FMT_HI   4
`define AOC_STAT_RANGE    5
`define AOC_STAT_FIFOFULL 6

// synchroniser image in reset: output enable bar, power-down, serial select bar high
`define AOC_PIN_RESET     5'h1c

// pipeline latency in sample-clock cycles
`define AOC_LATENCY       12

// code words
`define AOC_BIN_ZERO      14'h2000
`define AOC_GRAY_NEG      14'h3000
`define AOC_GRAY_POS      14'h2000

`endif

//--- core/aoc_pkg.sv
/*
 * Types for the converter output and mode control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package aoc_pkg;
    // output data formats
    typedef enum logic [1:0] {
        AOC_FMT_BINARY = 2'b00,
        AOC_FMT_TWOS   = 2'b01,
        AOC_FMT_GRAY   = 2'b10
    } aoc_fmt_e;

    // power states
    typedef enum logic [1:0] {
        AOC_PWR_RUN     = 2'b00,
        AOC_PWR_STANDBY = 2'b01,
        AOC_PWR_DOWN    = 2'b10
    } aoc_pwr_e;
endpackage
`default_nettype wire

//--- core/aoc_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`default_nettype none
module aoc_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // handshakes
    assign inReady  = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[rdPtr_r];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (clear) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

//--- core/aoc_output_ctrl.sv
/*
 * Output and mode control of a 14-bit pipelined converter: format coding,
 * out-of-range flag, 12-cycle output pipeline, data clock, output enable,
 * power-down and standby, and an AXI4-Lite register port.
 * Assumes the sample clock is clk; pins from outside are synchronised here;
 * the raw converter result arrives as an offset-binary code with over- and under-range flags.
 */
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
`include "aoc_regs.svh"

// Functional notes
// - With pins strapping the mode, the stabilizer pin low turns the stabilizer off, high on.
// - With pins strapping the mode, the format pin low gives offset binary, high twos complement.
// - Under serial control the formats are offset binary, twos complement and Gray code.
// - Powerdown pin high stops conversion and floats the outputs; low resumes it.
// - Under serial control a standby state keeps the reference alive for faster wake-up.
// - The range flag marks each out-of-range sample and travels with the same latency.
// - The range flag stays high until the input is back in range and one more conversion ends; here it drops with the first in-range sample.
// - Output drivers are on while output_enable_bar is low and floated while it is high; here the data clock driver ignores it.
// - Each sample appears 12 sample-clock cycles after its sampling edge.
// - The data clock output rises while data are valid unless its polarity is inverted.
// - Each sample is a 14-bit parallel word.
// - Offset binary and twos complement codes saturate with the range flag set.
// - Gray code gives 11 0000.. at negative, zero at mid and 10 0000.. at positive full scale.
module aoc_output_ctrl
    import aoc_pkg::*;
#(
    parameter int DATA_W  = 14,
    parameter int FIFO_D  = 16
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    // converter core side
    input  wire logic [DATA_W-1:0] coreCode,
    input  wire logic              coreOver,
    input  wire logic              coreUnder,
    output logic                   coreRun,
    output logic                   refPowered,
    output logic                   dutyStabOn,
    // pins
    input  wire logic              formatSelectPin,
    input  wire logic              stabilizerSelectPin,
    input  wire logic              serialSelectBar,
    input  wire logic              powerdownPin,
    input  wire logic              outputEnableBar,
    output logic      [DATA_W-1:0] dataOut,
    output logic      [DATA_W-1:0] dataOutOe,
    output logic                   rangeOut,
    output logic                   rangeOutOe,
    output logic                   dataClockOut,
    output logic                   dataClockOutOe,
    // capture stream through the fifo
    output logic      [DATA_W:0]   capData,
    output logic                   capValid,
    input  wire logic              capReady,
    // axi4-lite slave
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    localparam int LAT = `AOC_LATENCY;

    // pin synchronisers; in reset they read as strapped mode, powered down and floated
    // so that nothing drives and no serial setting applies before real levels settle
    logic [4:0] pinMeta_r;
    logic [4:0] pinSync_r;
    logic       fmtPin;
    logic       dcsPin;
    logic       serialMode;
    logic       pdPin;
    logic       oeBar;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_r <= `AOC_PIN_RESET;
            pinSync_r <= `AOC_PIN_RESET;
        end else begin
            pinMeta_r <= {outputEnableBar, powerdownPin, serialSelectBar,
                          stabilizerSelectPin, formatSelectPin};
            pinSync_r <= pinMeta_r;
        end
    end

    assign fmtPin     = pinSync_r[0];
    assign dcsPin     = pinSync_r[1];
    assign serialMode = !pinSync_r[2];
    assign pdPin      = pinSync_r[3];
    assign oeBar      = pinSync_r[4];

    // control register
    logic [31:0] ctrl_r;
    aoc_fmt_e    fmtSel;
    aoc_pwr_e    pwrState;
    logic        clkInvert;

    // effective format and stabilizer choice
    always_comb begin
        if (serialMode) begin
            fmtSel = (ctrl_r[`AOC_CTRL_FMT_HI:`AOC_CTRL_FMT_LO] == 2'b10) ? AOC_FMT_GRAY :
                     (ctrl_r[`AOC_CTRL_FMT_LO] ? AOC_FMT_TWOS : AOC_FMT_BINARY);
        end else begin
            fmtSel = fmtPin ? AOC_FMT_TWOS : AOC_FMT_BINARY;
        end
    end

    assign dutyStabOn = serialMode ? ctrl_r[`AOC_CTRL_DCS] : dcsPin;
    assign clkInvert  = serialMode && ctrl_r[`AOC_CTRL_CLKINV];

    // power state: pin power-down wins over serial standby
    always_comb begin
        if (pdPin) begin
            pwrState = AOC_PWR_DOWN;
        end else if (serialMode && ctrl_r[`AOC_CTRL_STANDBY]) begin
            pwrState = AOC_PWR_STANDBY;
        end else begin
            pwrState = AOC_PWR_RUN;
        end
    end

    assign coreRun    = (pwrState == AOC_PWR_RUN);
    assign refPowered = (pwrState != AOC_PWR_DOWN);

    // format coding and saturation of the incoming sample
    logic [DATA_W-1:0] binCode;
    logic [DATA_W-1:0] codedWord;
    logic              outRange;

    always_comb begin
        binCode  = coreCode;
        outRange = coreOver || coreUnder;
        if (coreOver) begin
            binCode = '1;
        end else if (coreUnder) begin
            binCode = '0;
        end
        case (fmtSel)
            AOC_FMT_TWOS: codedWord = binCode ^ `AOC_BIN_ZERO;
            AOC_FMT_GRAY: begin
                codedWord = (binCode ^ `AOC_BIN_ZERO) ^ ((binCode ^ `AOC_BIN_ZERO) >> 1);
                // both full-scale ends are pinned to their fixed codes; the plain
                // transform would give the wrong word at the positive end
                if (coreUnder || binCode == '0) begin
                    codedWord = `AOC_GRAY_NEG;
                end else if (coreOver || binCode == '1) begin
                    codedWord = `AOC_GRAY_POS;
                end
            end
            default: codedWord = binCode;
        endcase
    end

    // 12-stage output pipeline; word and flag share every stage
    logic [DATA_W:0] pipe_r [LAT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LAT; i++) begin
                pipe_r[i] <= '0;
            end
        end else if (coreRun) begin
            pipe_r[0] <= {outRange, codedWord};
            for (int i = 1; i < LAT; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    // latched outputs and drivers
    // after any stop the fill count restarts, so stale stages never count as valid
    logic pipeFill_r;
    logic [3:0] fillCnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fillCnt_r  <= '0;
            pipeFill_r <= 1'b0;
        end else if (!coreRun) begin
            fillCnt_r  <= '0;
            pipeFill_r <= 1'b0;
        end else if (fillCnt_r == 4'(LAT - 1)) begin
            pipeFill_r <= 1'b1;
        end else begin
            fillCnt_r <= fillCnt_r + 4'h1;
        end
    end

    assign dataOut        = pipe_r[LAT-1][DATA_W-1:0];
    assign rangeOut       = pipe_r[LAT-1][DATA_W];
    assign dataOutOe      = {DATA_W{!oeBar && !pdPin}};
    assign rangeOutOe     = !oeBar && !pdPin;
    assign dataClockOutOe = !pdPin;

    // data clock: high in the half period after each update once the pipeline is filled, low instead while clkInvert is set
    // the strobe is gated by clk itself so it rises on the same clk edge that updates the word
    logic dcoPhase_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dcoPhase_r <= 1'b0;
        end else begin
            dcoPhase_r <= coreRun && pipeFill_r;
        end
    end

    assign dataClockOut = (dcoPhase_r & clk) ^ clkInvert;

    // capture fifo fed with each valid output word
    logic fifoInReady;

    aoc_fifo #(
        .WIDTH(DATA_W + 1),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .clk     (clk),
        .rst_n   (rst_n),
        .clear   (!coreRun),
        .inData  (pipe_r[LAT-1]),
        .inValid (coreRun && pipeFill_r),
        .inReady (fifoInReady),
        .outData (capData),
        .outValid(capValid),
        .outReady(capReady)
    );

    // axi4-lite write channel
    // address and data are taken in either order; the answer waits for both
    logic        awHeld_r;
    logic        wHeld_r;
    logic [11:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;

    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            awAddr_r     <= '0;
            wData_r      <= '0;
            wStrb_r      <= '0;
            s_axi_bvalid <= 1'b0;
            ctrl_r       <= `AOC_CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (awHeld_r && wHeld_r) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr_r[11:2] == 10'(`AOC_CTRL_OFS >> 2)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wStrb_r[b]) begin
                            ctrl_r[b*8 +: 8] <= wData_r[b*8 +: 8];
                        end
                    end
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // sample counter for software
    // counts only words that left a filled pipeline
    logic [31:0] sampleCnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sampleCnt_r <= '0;
        end else if (coreRun && pipeFill_r) begin
            sampleCnt_r <= sampleCnt_r + 32'h1;
        end
    end

    // axi4-lite read channel
    // unmapped offsets read as zero and answer with a slave error
    logic [31:0] rdMux;

    always_comb begin
        rdMux = '0;
        case (s_axi_araddr[11:2])
            10'(`AOC_CTRL_OFS >> 2): rdMux = {26'h0, ctrl_r[5:0]};
            10'(`AOC_STATUS_OFS >> 2): begin
                rdMux[`AOC_STAT_PDOWN]    = (pwrState == AOC_PWR_DOWN);
                rdMux[`AOC_STAT_STANDBY]  = (pwrState == AOC_PWR_STANDBY);
                rdMux[`AOC_STAT_DCS]      = dutyStabOn;
                rdMux[`AOC_STAT_FMT_HI:`AOC_STAT_FMT_LO] = fmtSel;
                rdMux[`AOC_STAT_RANGE]    = rangeOut;
                rdMux[`AOC_STAT_FIFOFULL] = !fifoInReady;
            end
            10'(`AOC_SAMPLE_OFS >> 2): rdMux = {17'h0, pipe_r[LAT-1]};
            10'(`AOC_COUNT_OFS >> 2):  rdMux = sampleCnt_r;
            default: rdMux = '0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= (s_axi_araddr[11:2] > 10'(`AOC_COUNT_OFS >> 2)) ? 2'b10 : 2'b00;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/aoc_ctrl_monitor.sv
/*
 * Checker on the ports of the converter output control block.
 * Assumes pins settle two clock edges after a change; bound at the foot.
 */
`default_nettype none
module aoc_ctrl_monitor #(
    parameter int DATA_W = 14
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              coreOver,
    input wire logic              coreUnder,
    input wire logic              coreRun,
    input wire logic              refPowered,
    input wire logic              dutyStabOn,
    input wire logic              stabilizerSelectPin,
    input wire logic              serialSelectBar,
    input wire logic              powerdownPin,
    input wire logic              outputEnableBar,
    input wire logic [DATA_W-1:0] dataOutOe,
    input wire logic              rangeOut,
    input wire logic              rangeOutOe,
    input wire logic              dataClockOutOe,
    input wire logic [11:0]       s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [3:0] runCnt_r;
    wire logic  rawRange = coreOver | coreUnder;
    // consecutive running cycles, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) runCnt_r <= 4'h0;
        else if (!coreRun) runCnt_r <= 4'h0;
        else if (runCnt_r != 4'hf) runCnt_r <= runCnt_r + 4'h1;
    end

    property p_oeDown;
        powerdownPin [*3] |-> dataOutOe == '0 && !rangeOutOe && !dataClockOutOe;
    endproperty
    a_oeDown: assert property (p_oeDown) else $error("drivers on in power-down");
    property p_pdRun;
        powerdownPin [*3] |-> !coreRun && !refPowered;
    endproperty
    a_pdRun: assert property (p_pdRun) else $error("converting in power-down");
    // four cycles where the level must win over the synchroniser image left by reset
    property p_oeOn;
        (!powerdownPin && !outputEnableBar) [*4] |-> &dataOutOe && rangeOutOe;
    endproperty
    a_oeOn: assert property (p_oeOn) else $error("drivers off while enabled");
    property p_oeBar;
        outputEnableBar [*3] |-> dataOutOe == '0 && !rangeOutOe;
    endproperty
    a_oeBar: assert property (p_oeBar) else $error("drivers on while disabled");
    property p_stabOn;
        (serialSelectBar && stabilizerSelectPin) [*4] |-> dutyStabOn;
    endproperty
    a_stabOn: assert property (p_stabOn) else $error("stabilizer off with pin high");
    property p_stabOff;
        (serialSelectBar && !stabilizerSelectPin) [*4] |-> !dutyStabOn;
    endproperty
    a_stabOff: assert property (p_stabOff) else $error("stabilizer on with pin low");
    property p_range;
        coreRun && runCnt_r >= 4'd13 |-> rangeOut == $past(rawRange, 12);
    endproperty
    a_range: assert property (p_range) else $error("range flag latency wrong");
    property p_slverr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h00c |=> s_axi_rresp == 2'b10;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read not refused");

    c_range: cover property (rangeOut && runCnt_r >= 4'd13);
    c_down: cover property (powerdownPin [*3]);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind aoc_output_ctrl aoc_ctrl_monitor #(.DATA_W(DATA_W)) uMon (.*);
`default_nettype wire

//--- testbench/aoc_capture_sink.sv
/*
 * Capture-side model: accepts words from the capture stream and sorts them.
 * Assumes the bench holds it off through stall.
 */
`default_nettype none
module aoc_capture_sink (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [14:0] capData,
    input  wire logic        capValid,
    output logic             capReady,
    input  wire logic        stall
);
    int unsigned taken_r;
    logic        overSeen_r;
    logic        underSeen_r;
    // ready only while not held off
    assign capReady = !stall;
    // count accepted words, classify by flag and top data bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            taken_r <= '0;
            overSeen_r <= 1'b0;
            underSeen_r <= 1'b0;
        end else if (capValid && capReady) begin
            taken_r <= taken_r + 32'h1;
            if (capData[14] && capData[13]) overSeen_r <= 1'b1;
            if (capData[14] && !capData[13]) underSeen_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- testbench/test_adc_output_mode_control.sv
/*
 * Self-checking bench for the converter output control block.
 * Assumes the capture sink model and the bound checker.
 */
`default_nettype none
`include "aoc_regs.svh"
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module test_adc_output_mode_control
    import aoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, stall = 1'b0;
    logic [13:0] coreCode = 14'h0;
    logic        coreOver = 1'b0, coreUnder = 1'b0, powerdownPin = 1'b0;
    logic        formatSelectPin = 1'b0, stabilizerSelectPin = 1'b1, outputEnableBar = 1'b0;
    logic        serialSelectBar = 1'b1; // pins strap the mode
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [13:0] dataOut, dataOutOe;
    logic        rangeOut, rangeOutOe, dataClockOut, dataClockOutOe;
    logic        coreRun, refPowered, dutyStabOn, capValid, capReady;
    logic [14:0] capData;
    int          miscompares = 0, checkCount = 0;

    aoc_output_ctrl DUT (.*);
    aoc_capture_sink sink (.*);

    always #5 clk = ~clk;

    task giveVerdict;
        if (miscompares == 0 && checkCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task axiWrite(input logic [11:0] a, input logic [31:0] d);
        int   n;
        logic aw, w, b;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            if (b) `CHK(s_axi_bresp, 2'b00)
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) miscompares++;
        if (n == 40) giveVerdict();
    endtask
    task axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ar, rv;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) miscompares++;
        if (n == 40) giveVerdict();
    endtask
    function automatic logic [13:0] expWord(input logic [1:0] f, input logic [13:0] c);
        if (f == AOC_FMT_TWOS) return {~c[13], c[12:0]};
        if (f != AOC_FMT_GRAY) return c;
        return (c == 14'h0) ? `AOC_GRAY_NEG : (c == `AOC_BIN_ZERO) ? 14'h0 : `AOC_GRAY_POS;
    endfunction
    // one sample for one cycle, then judged exactly at its output cycle
    task sample(input logic [13:0] c, input logic ov, input logic un, input logic [13:0] e);
        @(posedge clk);
        coreCode <= c;
        coreOver <= ov;
        coreUnder <= un;
        @(posedge clk);
        coreCode <= ~c;
        coreOver <= 1'b0;
        coreUnder <= 1'b0;
        cyc(11);
        #1;
        `CHK({rangeOut, dataOut}, {ov | un, e})
    endtask
    task runFormats(input logic [1:0] f);
        sample(14'h0, 1'b0, 1'b1, expWord(f, 14'h0));
        sample(`AOC_BIN_ZERO, 1'b0, 1'b0, expWord(f, `AOC_BIN_ZERO));
        sample(14'h3fff, 1'b1, 1'b0, expWord(f, 14'h3fff));
    endtask
    task scenRegs;
        logic [31:0] d;
        logic [1:0]  r;
        axiRead(`AOC_CTRL_OFS, d, r);
        `CHK(d, `AOC_CTRL_RESET)
        axiRead(12'h010, d, r);
        `CHK({r, d}, 34'h200000000)
    endtask
    task scenPower;
        @(posedge clk);
        powerdownPin <= 1'b1;
        cyc(4);
        #1;
        `CHK({dataOutOe, rangeOutOe, dataClockOutOe, coreRun, refPowered}, 18'h0)
        @(posedge clk);
        powerdownPin <= 1'b0;
        cyc(4);
        #1;
        `CHK({dataOutOe, rangeOutOe, dataClockOutOe}, 16'hffff)
        @(posedge clk);
        outputEnableBar <= 1'b1;
        cyc(4);
        #1;
        `CHK({dataOutOe, rangeOutOe, dataClockOutOe}, 16'h1)
        @(posedge clk);
        outputEnableBar <= 1'b0;
        cyc(14); // wake-up allowance before samples are used
        sample(14'h1234, 1'b0, 1'b0, 14'h1234);
    endtask
    task scenStrap;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            formatSelectPin <= i[0];
            stabilizerSelectPin <= i[1];
            cyc(4);
            #1;
            `CHK(dutyStabOn, i[1])
            runFormats({1'b0, i[0]});
        end
    endtask
    task scenSerial;
        @(posedge clk);
        serialSelectBar <= 1'b0;
        for (int f = 0; f < 3; f++) begin
            axiWrite(`AOC_CTRL_OFS, {29'h0, f[1:0], 1'b0});
            cyc(3);
            #1;
            `CHK(dutyStabOn, 1'b0)
            runFormats(f[1:0]);
        end
        axiWrite(`AOC_CTRL_OFS, 32'h28);
        @(posedge clk);
        #1;
        `CHK(dataClockOut, 1'b0)
        axiWrite(`AOC_CTRL_OFS, 32'h18);
        cyc(2);
        #1;
        `CHK({coreRun, refPowered}, 2'b01)
        axiWrite(`AOC_CTRL_OFS, `AOC_CTRL_RESET);
        serialSelectBar <= 1'b1;
        formatSelectPin <= 1'b0;
        cyc(16);
        #1;
        `CHK(dataClockOut, 1'b1)
    endtask
    task scenHold;
        @(posedge clk);
        coreCode <= 14'h3fff;
        coreOver <= 1'b1;
        cyc(2);
        coreCode <= 14'h1000;
        coreOver <= 1'b0;
        cyc(10);
        #1;
        `CHK(rangeOut, 1'b1)
        @(posedge clk);
        #1;
        `CHK(rangeOut, 1'b1)
        @(posedge clk);
        #1;
        `CHK({rangeOut, dataOut}, 15'h1000)
        `CHK({sink.overSeen_r, sink.underSeen_r}, 2'b11)
    endtask
    task scenFifo;
        logic [31:0] d;
        logic [1:0]  r;
        logic [14:0] head;
        int          t0;
        @(posedge clk);
        stall <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            axiRead(`AOC_STATUS_OFS, d, r);
            if (d[`AOC_STAT_FIFOFULL]) break;
        end
        #1;
        head = capData;
        `CHK(d[`AOC_STAT_FIFOFULL], 1'b1)
        cyc(5);
        #1;
        `CHK({capValid, capData}, {1'b1, head})
        t0 = sink.taken_r;
        @(posedge clk);
        stall <= 1'b0;
        cyc(20);
        `CHK(sink.taken_r - t0 >= 16, 1'b1)
    endtask

    // reset, then every scenario in turn
    initial begin
        cyc(6);
        rst_n <= 1'b1;
        scenRegs();
        scenPower();
        scenStrap();
        scenSerial();
        scenHold();
        scenFifo();
        giveVerdict();
    end
endmodule
`default_nettype wire
